// ---- hw/psi_status_irq.sv ----
// status summary, event flags and interrupt pin control of the transceiver
`timescale 1ns/1ps
// Function
// - bit 2 shows resolved duplex, 1 full
// - speed and duplex valid only with link
// - bit 1 reads 1 at 10 Mb/s
// - bit 0 copies link, read never clears
// - link bit 1 with valid link
// - control bits 15:3 ignore writes, read zero
// - test bit forces an interrupt
// - forced interrupt persists until bit cleared
// - global enable gates event interrupts
// - output enable makes shared pin interrupt output
// - enable low: shared pin is power-down input
// - seven event sources feed the interrupt
// - flags set even when event disabled
// - summary flag shows pending, event read clears
// - each flag cleared by read returning it
module psi_status_irq
  import psi_pkg::*;
(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  // management register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  output logic                   reg_rvalid_out,
  // resolved link state from the transceiver core
  input  wire logic              link_up_in,
  input  wire logic              speed10_in,
  input  wire logic              full_duplex_in,
  input  wire logic              an_enable_in,
  input  wire logic              an_complete_in,
  // one-cycle event pulses
  input  wire logic              link_quality_evt_in,
  input  wire logic              energy_detect_evt_in,
  input  wire logic              counter_half_full_evt_in,
  // shared power-down / interrupt pin
  input  wire logic              powerdown_or_irq_pin_in,
  output logic                   powerdown_or_irq_pin_out,
  output logic                   powerdown_or_irq_pin_oe_n_out,
  // power-down request to the core
  output logic                   powerdown_out
);
  logic [CTL_W-1:0]   ctl_q;
  logic [NUM_EVT-1:0] evt_en_q;
  logic [NUM_EVT-1:0] evt_stat_q;
  logic [NUM_EVT-1:0] evt_stat_d;
  logic [NUM_EVT-1:0] evt_set;
  logic [DATA_W-1:0]  rdata_q;
  logic               rvalid_q;
  logic               pin_q;
  logic               pin_oe_n_q;
  logic               pd_q;
  logic               link_chg;
  logic               speed_chg;
  logic               duplex_chg;
  logic               an_rise;
  logic               res_valid;
  logic               event_irq;
  logic               irq_pending;
  logic               rd_evt;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  psi_change_det u_chg (
    .clock_in         (clock_in),
    .rst_in           (rst_in),
    .link_in          (link_up_in),
    .speed10_in       (speed10_in),
    .duplex_in        (full_duplex_in),
    .an_done_in       (an_complete_in),
    .link_chg_out     (link_chg),
    .speed_chg_out    (speed_chg),
    .duplex_chg_out   (duplex_chg),
    .an_done_rise_out (an_rise)
  );

  // speed and duplex carry meaning only with a link and a settled or disabled negotiation
  assign res_valid = link_up_in & (~an_enable_in | an_complete_in);

  always_comb begin
    evt_set          = '0;
    evt_set[EV_LQ]   = link_quality_evt_in;
    evt_set[EV_ED]   = energy_detect_evt_in;
    evt_set[EV_LINK] = link_chg;
    evt_set[EV_SPD]  = speed_chg;
    evt_set[EV_DUP]  = duplex_chg;
    evt_set[EV_ANC]  = an_rise;
    evt_set[EV_CTR]  = counter_half_full_evt_in;
  end

  assign rd_evt = reg_rd_in & hit(reg_addr_in, OFS_EVENT_STAT);

  // a read clears what it returns; an event in the same cycle survives
  always_comb begin
    evt_stat_d = evt_stat_q;
    if (rd_evt) begin
      evt_stat_d = '0;
    end
    evt_stat_d = evt_stat_d | evt_set;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      evt_stat_q <= EVT_RESET;
    end else begin
      evt_stat_q <= evt_stat_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctl_q    <= CTL_RESET;
      evt_en_q <= EVT_RESET;
    end else if (reg_wr_in) begin
      if (hit(reg_addr_in, OFS_IRQ_CONTROL)) begin
        ctl_q <= reg_wdata_in[CTL_W-1:0];
      end else if (hit(reg_addr_in, OFS_EVENT_STAT)) begin
        evt_en_q <= reg_wdata_in[EVT_EN_LSB +: NUM_EVT];
      end
    end
  end

  assign event_irq   = ctl_q[CTL_GLOBAL_BIT] & (|(evt_stat_q & evt_en_q));
  // the test bit holds the pin as long as it stays set, independent of events
  assign irq_pending = event_irq | ctl_q[CTL_TEST_BIT];

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_q  <= RDATA_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_q <= RDATA_RESET;
        if (hit(reg_addr_in, OFS_LINK_SUMMARY)) begin
          rdata_q[SUM_LINK_BIT]    <= link_up_in;
          rdata_q[SUM_SPEED10_BIT] <= speed10_in & res_valid;
          rdata_q[SUM_DUPLEX_BIT]  <= full_duplex_in & res_valid;
          rdata_q[SUM_AN_DONE_BIT] <= an_complete_in;
          rdata_q[SUM_IRQ_BIT]     <= irq_pending;
        end else if (hit(reg_addr_in, OFS_IRQ_CONTROL)) begin
          rdata_q[CTL_W-1:0] <= ctl_q;
        end else if (hit(reg_addr_in, OFS_EVENT_STAT)) begin
          rdata_q[EVT_STAT_LSB +: NUM_EVT] <= evt_stat_q;
          rdata_q[EVT_EN_LSB +: NUM_EVT]   <= evt_en_q;
        end
      end
    end
  end

  // pin drive; power-down only honoured while the pin is an input
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_q      <= 1'b1;
      pin_oe_n_q <= 1'b1;
      pd_q       <= 1'b0;
    end else begin
      pin_q      <= ~irq_pending;
      pin_oe_n_q <= ~ctl_q[CTL_OE_BIT];
      pd_q       <= ~ctl_q[CTL_OE_BIT] & ~powerdown_or_irq_pin_in;
    end
  end

  assign reg_rdata_out                 = rdata_q;
  assign reg_rvalid_out                = rvalid_q;
  assign powerdown_or_irq_pin_out      = pin_q;
  assign powerdown_or_irq_pin_oe_n_out = pin_oe_n_q;
  assign powerdown_out                 = pd_q;

  a_rsvd_read_zero: assert property (@(posedge clock_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == OFS_IRQ_CONTROL |=> reg_rdata_out[15:3] == 13'h0000)
    else $error("reserved control bits read nonzero");

  a_test_force_pin: assert property (@(posedge clock_in) disable iff (rst_in)
    ctl_q[CTL_TEST_BIT] |=> !powerdown_or_irq_pin_out)
    else $error("test bit did not drive pin low");

  a_test_hold_pin: assert property (@(posedge clock_in) disable iff (rst_in)
    ctl_q[CTL_TEST_BIT] [*4] |=> !powerdown_or_irq_pin_out [*1])
    else $error("forced interrupt dropped while test bit set");

  a_global_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    !ctl_q[CTL_GLOBAL_BIT] && !ctl_q[CTL_TEST_BIT] |=> powerdown_or_irq_pin_out)
    else $error("interrupt without global enable");

  a_oe_drive: assert property (@(posedge clock_in) disable iff (rst_in)
    ##1 powerdown_or_irq_pin_oe_n_out == !$past(ctl_q[CTL_OE_BIT]))
    else $error("pin direction does not follow enable");

  a_pd_input: assert property (@(posedge clock_in) disable iff (rst_in)
    ctl_q[CTL_OE_BIT] |=> !powerdown_out)
    else $error("power-down taken while pin is output");

  a_flag_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
    link_quality_evt_in || (evt_stat_q[EV_LQ] && !rd_evt) |=> evt_stat_q[EV_LQ])
    else $error("event flag not held until read");

  a_read_clears: assert property (@(posedge clock_in) disable iff (rst_in)
    rd_evt && evt_set == '0 |=> evt_stat_q == '0 && reg_rdata_out[15:9] == $past(evt_stat_q))
    else $error("event read did not return and clear flags");

  a_summary_irq: assert property (@(posedge clock_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == OFS_LINK_SUMMARY |=> reg_rdata_out[SUM_IRQ_BIT] == !powerdown_or_irq_pin_out)
    else $error("summary flag disagrees with pin");

  a_duplex_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == OFS_LINK_SUMMARY && !link_up_in |=> reg_rdata_out[2:0] == 3'h0)
    else $error("speed or duplex reported without link");

  a_link_mirror: assert property (@(posedge clock_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == OFS_LINK_SUMMARY |=> reg_rdata_out[SUM_LINK_BIT] == $past(link_up_in))
    else $error("link bit does not mirror link");

  c_event_irq: cover property (@(posedge clock_in) disable iff (rst_in)
    event_irq ##1 !powerdown_or_irq_pin_out);
  c_read_clear: cover property (@(posedge clock_in) disable iff (rst_in)
    rd_evt && |evt_stat_q);
  c_powerdown: cover property (@(posedge clock_in) disable iff (rst_in) powerdown_out);
endmodule

// ---- hw/psi_pkg.sv ----
// constants for the transceiver status summary and interrupt control block
package psi_pkg;
  localparam int unsigned ADDR_W       = 5;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned NUM_EVT      = 7;
  // register offsets
  localparam logic [4:0] OFS_LINK_SUMMARY = 5'h10;
  localparam logic [4:0] OFS_IRQ_CONTROL  = 5'h11;
  localparam logic [4:0] OFS_EVENT_STAT   = 5'h12;
  // link_summary_status fields
  localparam int unsigned SUM_LINK_BIT    = 0;
  localparam int unsigned SUM_SPEED10_BIT = 1;
  localparam int unsigned SUM_DUPLEX_BIT  = 2;
  localparam int unsigned SUM_AN_DONE_BIT = 4;
  localparam int unsigned SUM_IRQ_BIT     = 7;
  // irq_control fields
  localparam int unsigned CTL_OE_BIT      = 0;
  localparam int unsigned CTL_GLOBAL_BIT  = 1;
  localparam int unsigned CTL_TEST_BIT    = 2;
  localparam int unsigned CTL_W           = 3;
  localparam logic [2:0]  CTL_RESET       = 3'h0;
  // event_status_and_enables: pending flags in 15:9, enables in 6:0
  localparam int unsigned EVT_STAT_LSB    = 9;
  localparam int unsigned EVT_EN_LSB      = 0;
  localparam logic [6:0]  EVT_RESET       = 7'h00;
  // event index inside the 7-bit vectors
  localparam int unsigned EV_CTR          = 0;
  localparam int unsigned EV_ANC          = 1;
  localparam int unsigned EV_DUP          = 2;
  localparam int unsigned EV_SPD          = 3;
  localparam int unsigned EV_LINK         = 4;
  localparam int unsigned EV_ED           = 5;
  localparam int unsigned EV_LQ           = 6;
  localparam logic [15:0] RDATA_RESET     = 16'h0000;
endpackage

// ---- hw/psi_change_det.sv ----
// change detector for link, speed and duplex plus auto-negotiation completion edge
`timescale 1ns/1ps
module psi_change_det
  import psi_pkg::*;
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // watched levels
  input  wire logic link_in,
  input  wire logic speed10_in,
  input  wire logic duplex_in,
  input  wire logic an_done_in,
  // one-cycle change pulses
  output logic      link_chg_out,
  output logic      speed_chg_out,
  output logic      duplex_chg_out,
  output logic      an_done_rise_out
);
  logic [3:0] prev_q;

  // previous values start at zero so a level already high after reset reads as a change
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= {an_done_in, duplex_in, speed10_in, link_in};
    end
  end

  always_comb begin
    link_chg_out     = link_in ^ prev_q[0];
    speed_chg_out    = speed10_in ^ prev_q[1];
    duplex_chg_out   = duplex_in ^ prev_q[2];
    an_done_rise_out = an_done_in & ~prev_q[3];
  end
endmodule

// ---- testbench/psi_host_model.sv ----
// host side model: management master and far end of the shared pin
`timescale 1ns/1ps
module psi_host_model
  import psi_pkg::*;
(
  // clock
  input  wire logic              clock_in,
  // management port
  output logic      [ADDR_W-1:0] reg_addr_out,
  output logic                   reg_wr_out,
  output logic      [DATA_W-1:0] reg_wdata_out,
  output logic                   reg_rd_out,
  input  wire logic [DATA_W-1:0] reg_rdata_in,
  input  wire logic              reg_rvalid_in,
  // shared pin
  input  wire logic              pin_drive_in,
  input  wire logic              pin_oe_n_in,
  input  wire logic              pd_req_in,
  output logic                   pin_level_out
);
  // driven by the block while output enabled, else pulled up unless the host pulls it low for power-down
  assign pin_level_out = !pin_oe_n_in ? pin_drive_in : !pd_req_in;
  initial begin
    reg_addr_out = '0;
    reg_wr_out = 1'b0;
    reg_wdata_out = '0;
    reg_rd_out = 1'b0;
  end
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clock_in);
    reg_wr_out = 1'b0;
  endtask
  // answer left unknown when it never comes, so the compare fails
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    d = 'x;
    @(negedge clock_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clock_in);
    reg_rd_out = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (reg_rvalid_in === 1'b1) begin
        d = reg_rdata_in;
        break;
      end
      @(negedge clock_in);
    end
  endtask
endmodule

// ---- testbench/test_phy_status_irq_control.sv ----
// self-checking bench for the status summary and interrupt control block
`timescale 1ns/1ps
module test_phy_status_irq_control;
  import psi_pkg::*;
  logic              clock_in = 1'b0;
  logic              rst_in   = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic              wr, rd, rvalid, lnk, spd, dup, ane, anc, lq, ed, ctr;
  logic              pin_in, pin_out, oe_n, pd, pd_req;
  int                flags, en, ctl, miscompares, samples_checked, cycles;
  integer            seed     = 32'hc3e4;

  always #2.5 clock_in = !clock_in;

  psi_status_irq u_psi_status_irq (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .link_up_in(lnk),
    .speed10_in(spd), .full_duplex_in(dup), .an_enable_in(ane), .an_complete_in(anc), .link_quality_evt_in(lq),
    .energy_detect_evt_in(ed), .counter_half_full_evt_in(ctr), .powerdown_or_irq_pin_in(pin_in),
    .powerdown_or_irq_pin_out(pin_out), .powerdown_or_irq_pin_oe_n_out(oe_n), .powerdown_out(pd));
  psi_host_model u_psi_host_model (.clock_in(clock_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .pin_drive_in(pin_out), .pin_oe_n_in(oe_n), .pd_req_in(pd_req), .pin_level_out(pin_in));

  function automatic logic [15:0] exp_sum();
    logic ok;
    ok = lnk && (!ane || anc);
    return {8'h00, ctl[1] && ((flags & en) != 0), 2'b00, anc, 1'b0, dup && ok, spd && ok, lnk};
  endfunction
  function automatic logic exp_pin();
    return !(ctl[2] || (ctl[1] && (flags & en) != 0));
  endfunction
  task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    u_psi_host_model.read_reg(a, d);
    samples_checked++;
    if (d !== exp) begin
      miscompares++;
      $display("wrong value at %0t: reg %h read %h expected %h", $time, a, d, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s is %b", $time, what, got);
    end
  endtask
  // reading the event register empties the model's flags too
  task automatic rd_evt();
    chk_reg(OFS_EVENT_STAT, 16'((flags << EVT_STAT_LSB) | en));
    flags = 0;
  endtask
  task automatic set_ctl(input int v);
    ctl = v;
    u_psi_host_model.write_reg(OFS_IRQ_CONTROL, 16'(v));
  endtask
  // v is {link, speed10, duplex, an enable, an complete}
  task automatic drive(input logic [4:0] v);
    @(negedge clock_in);
    if (v[4] != lnk) flags |= 1 << EV_LINK;
    if (v[3] != spd) flags |= 1 << EV_SPD;
    if (v[2] != dup) flags |= 1 << EV_DUP;
    if (v[0] && !anc) flags |= 1 << EV_ANC;
    {lnk, spd, dup, ane, anc} = v;
  endtask
  task automatic fire(input int i);
    case (i)
      EV_LINK: drive({!lnk, spd, dup, ane, anc});
      EV_SPD:  drive({lnk, !spd, dup, ane, anc});
      EV_DUP:  drive({lnk, spd, !dup, ane, anc});
      EV_ANC: begin
        drive({lnk, spd, dup, ane, 1'b0});
        drive({lnk, spd, dup, ane, 1'b1});
      end
      default: begin
        @(negedge clock_in);
        {lq, ed, ctr} = {i == EV_LQ, i == EV_ED, i == EV_CTR};
        flags |= 1 << i;
        @(negedge clock_in);
        {lq, ed, ctr} = 3'b000;
      end
    endcase
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    {lnk, spd, dup, ane, anc, lq, ed, ctr, pd_req} = 9'h000;
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    chk_reg(OFS_IRQ_CONTROL, 16'h0000);
    chk_reg(OFS_EVENT_STAT, 16'h0000);
    chk_reg(5'h05, 16'h0000);
    repeat (16) begin
      drive(5'($random(seed)));
      repeat (3) @(negedge clock_in);
      chk_reg(OFS_LINK_SUMMARY, exp_sum());
      chk_reg(OFS_LINK_SUMMARY, exp_sum());
    end
    u_psi_host_model.write_reg(OFS_LINK_SUMMARY, 16'hffff);
    rd_evt();
    chk_reg(OFS_LINK_SUMMARY, exp_sum());
    // ones written to the reserved bits must not stick
    set_ctl('hffff);
    chk_reg(OFS_IRQ_CONTROL, 16'h0007);
    // pass 0 all enabled, pass 1 random enables, pass 2 random enables with the global gate off
    for (int p = 0; p < 3; p++) begin
      en = (p != 0) ? ($random(seed) & 'h7f) : 'h7f;
      u_psi_host_model.write_reg(OFS_EVENT_STAT, 16'(en));
      set_ctl((p == 2) ? 1 : 3);
      for (int i = 0; i < NUM_EVT; i++) begin
        fire(i);
        repeat (3) @(negedge clock_in);
        chk_pin(pin_in, exp_pin(), "irq pin");
        chk_reg(OFS_LINK_SUMMARY, exp_sum());
        rd_evt();
        repeat (3) @(negedge clock_in);
        chk_pin(pin_in, 1'b1, "irq pin after read");
      end
    end
    set_ctl(5);
    rd_evt();
    repeat (6) begin
      @(negedge clock_in);
      chk_pin(pin_in, 1'b0, "forced irq");
    end
    set_ctl(1);
    repeat (3) @(negedge clock_in);
    chk_pin(pin_in, 1'b1, "force cleared");
    set_ctl(0);
    pd_req = 1'b1;
    repeat (3) @(negedge clock_in);
    chk_pin(pd, 1'b1, "power-down");
    chk_pin(oe_n, 1'b1, "pin enable");
    // the forced interrupt pulls the pin low; as an output it must not read back as power-down
    set_ctl(5);
    repeat (3) @(negedge clock_in);
    chk_pin(pin_in, exp_pin(), "irq pin as output");
    chk_pin(pd, 1'b0, "power-down as output");
    chk_pin(oe_n, 1'b0, "pin enable");
    summarize();
  end
endmodule
